/* shared/sees_pkg.sv */
// package: slot event status and control constants
package sees_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // configuration offsets
  localparam logic [7:0] SLOT_CONTROL_OFS = 8'hA8;
  localparam logic [7:0] SLOT_STATUS_OFS = 8'hAA;
  // reset values
  localparam logic [15:0] STATUS_RESET = 16'h0010;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  // status bits that hold sticky events
  localparam logic [15:0] FLAG_MASK = 16'h011F;
  // status bits that mirror live slot state
  localparam logic [15:0] STATE_MASK = 16'h00E0;
  // status field positions
  localparam int STAT_BUTTON_BIT = 0;
  localparam int STAT_FAULT_BIT = 1;
  localparam int STAT_LATCH_CHG_BIT = 2;
  localparam int STAT_PRESENCE_CHG_BIT = 3;
  localparam int STAT_CMD_DONE_BIT = 4;
  localparam int STAT_LATCH_STATE_BIT = 5;
  localparam int STAT_PRESENCE_BIT = 6;
  localparam int STAT_INTERLOCK_BIT = 7;
  localparam int STAT_LINK_CHG_BIT = 8;
  // control field positions
  localparam int CTL_BUTTON_EN_BIT = 0;
  localparam int CTL_FAULT_EN_BIT = 1;
  localparam int CTL_LATCH_EN_BIT = 2;
  localparam int CTL_PRESENCE_EN_BIT = 3;
  localparam int CTL_CMD_DONE_EN_BIT = 4;
  localparam int CTL_HOTPLUG_EN_BIT = 5;
  // events that may raise either request
  localparam logic [15:0] WAKE_EVENT_MASK = 16'h000F;
  localparam int BYTE_W = 8;
  // power states
  localparam logic [1:0] PSTATE_D0 = 2'h0;
endpackage

/* logic/sees_event_flag.sv */
// file: one sticky slot event flag, set wins over clear
`timescale 1ns/1ps
module sees_event_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // event and clear
  input wire logic set_evt,
  input wire logic clear_req,
  // flag
  output logic flag
);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flag <= RESET_VAL;
    end else if (clk_en) begin
      // an event landing on the clear cycle must not be lost
      if (set_evt) begin
        flag <= 1'b1;
      end else if (clear_req) begin
        flag <= 1'b0;
      end
    end
  end
endmodule

/* logic/sees_slot_events.sv */
// file: slot event enables, slot status and request gating
// Operation
// RQ1 - fault enable set: pending fault flag raises interrupt or wake request
// RQ2 - button enable set: pending button flag raises interrupt or wake request
// RQ3 - interrupt only with hot-plug and message interrupt enables both set
// RQ4 - wake request in low power states only with power event enable
// RQ5 - 16-bit status at AAh resets to 0010h
// RQ6 - status ignores ordinary writes; hardware sets, write one clears
// RQ7 - writing one clears an event bit, writing zero leaves it
// RQ8 - fault flag follows the slot fault pin, zero when no fault; here the pin sets a sticky flag that stays until a write of one clears it
// RQ9 - requests held while flag and enable set, drop after clear
`timescale 1ns/1ps
module sees_slot_events (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [sees_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic [sees_pkg::DATA_W-1:0] cfg_wdata,
  input wire logic [1:0] cfg_be,
  output logic [sees_pkg::DATA_W-1:0] cfg_rdata,
  output logic cfg_rvalid,
  // slot sensors
  input wire logic attention_button_press,
  input wire logic slot_power_fault_pin,
  input wire logic latch_sensor_change,
  input wire logic presence_change,
  input wire logic link_state_change,
  input wire logic latch_sensor_open,
  input wire logic card_present,
  input wire logic interlock_engaged,
  // enables kept elsewhere and power state
  input wire logic message_interrupt_enable,
  input wire logic power_event_enable,
  input wire logic [1:0] power_state,
  // requests
  output logic hotplug_irq_req,
  output logic pme_req
);
  import sees_pkg::*;

  logic [DATA_W-1:0] slot_event_control;
  logic cmd_write_seen;
  logic [DATA_W-1:0] stat_flags;
  logic [DATA_W-1:0] set_vec;
  logic [DATA_W-1:0] clr_vec;
  logic [DATA_W-1:0] state_vec;
  logic [DATA_W-1:0] slot_event_status;
  logic [DATA_W-1:0] wake_pending;
  logic ctl_wr;
  logic stat_wr;
  logic in_d0;
  logic hotplug_interrupt_enable;
  logic next_irq;
  logic next_pme;

  function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] be);
    lane_mask = {{BYTE_W{be[1]}}, {BYTE_W{be[0]}}};
  endfunction

  assign ctl_wr = cfg_wr && (cfg_addr == SLOT_CONTROL_OFS);
  assign stat_wr = cfg_wr && (cfg_addr == SLOT_STATUS_OFS);
  assign in_d0 = (power_state == PSTATE_D0);
  assign hotplug_interrupt_enable = slot_event_control[CTL_HOTPLUG_EN_BIT];

  always_comb begin
    set_vec = '0;
    set_vec[STAT_BUTTON_BIT] = attention_button_press;
    set_vec[STAT_FAULT_BIT] = slot_power_fault_pin; // RQ8
    set_vec[STAT_LATCH_CHG_BIT] = latch_sensor_change;
    set_vec[STAT_PRESENCE_CHG_BIT] = presence_change;
    set_vec[STAT_CMD_DONE_BIT] = cmd_write_seen;
    set_vec[STAT_LINK_CHG_BIT] = link_state_change;
  end

  // only a written one clears; zeros and absent lanes leave bits
  assign clr_vec = stat_wr ? (cfg_wdata & lane_mask(cfg_be)) : '0; // RQ7

  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_flag
      if (FLAG_MASK[gi]) begin : g_cell
        sees_event_flag #(
          .RESET_VAL(STATUS_RESET[gi])
        ) u_flag (
          .core_clk(core_clk),
          .sys_rst(sys_rst),
          .clk_en(clk_en),
          .set_evt(set_vec[gi]),
          .clear_req(clr_vec[gi]), // RQ6
          .flag(stat_flags[gi])
        );
      end else begin : g_none
        assign stat_flags[gi] = 1'b0;
      end
    end
  endgenerate

  always_comb begin
    state_vec = '0;
    state_vec[STAT_LATCH_STATE_BIT] = latch_sensor_open;
    state_vec[STAT_PRESENCE_BIT] = card_present;
    state_vec[STAT_INTERLOCK_BIT] = interlock_engaged;
  end

  // live state bits ignore writes; reserved bits stay zero
  assign slot_event_status = stat_flags | (state_vec & STATE_MASK); // RQ5

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      slot_event_control <= CONTROL_RESET;
    end else if (clk_en && ctl_wr) begin
      slot_event_control <= (slot_event_control & ~lane_mask(cfg_be)) |
                            (cfg_wdata & lane_mask(cfg_be));
    end
  end

  // any control write counts as a command; done flags two cycles later
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cmd_write_seen <= 1'b0;
    end else if (clk_en) begin
      cmd_write_seen <= ctl_wr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_rdata <= '0;
      cfg_rvalid <= 1'b0;
    end else if (clk_en) begin
      cfg_rvalid <= cfg_rd;
      if (!cfg_rd) begin
        cfg_rdata <= cfg_rdata;
      end else if (cfg_addr == SLOT_STATUS_OFS) begin
        cfg_rdata <= slot_event_status; // RQ5
      end else if (cfg_addr == SLOT_CONTROL_OFS) begin
        cfg_rdata <= slot_event_control;
      end else begin
        cfg_rdata <= '0;
      end
    end
  end

  assign wake_pending = stat_flags & slot_event_control & WAKE_EVENT_MASK;

  always_comb begin
    // RQ1 RQ2 RQ9 level requests follow flag and enable
    next_irq = (|wake_pending) ||
               (stat_flags[STAT_CMD_DONE_BIT] &&
                slot_event_control[CTL_CMD_DONE_EN_BIT]);
    // RQ3
    next_irq = next_irq && hotplug_interrupt_enable &&
               message_interrupt_enable && in_d0;
    // RQ4 command completion never wakes the link
    next_pme = (|wake_pending) && power_event_enable && !in_d0;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hotplug_irq_req <= 1'b0;
      pme_req <= 1'b0;
    end else if (clk_en) begin
      hotplug_irq_req <= next_irq; // RQ9
      pme_req <= next_pme; // RQ9
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  fault_irq_path_a: assert property ( // RQ1
    clk_en && stat_flags[STAT_FAULT_BIT] &&
    slot_event_control[CTL_FAULT_EN_BIT] && hotplug_interrupt_enable &&
    message_interrupt_enable && in_d0 |=> hotplug_irq_req)
    else $error("enabled fault did not raise interrupt");
  fault_gated_a: assert property ( // RQ1
    clk_en && !slot_event_control[CTL_FAULT_EN_BIT] &&
    (stat_flags & slot_event_control & 16'h001D) == 16'h0000 |=>
    !hotplug_irq_req && !pme_req)
    else $error("disabled fault raised a request");
  button_pme_path_a: assert property ( // RQ2
    clk_en && stat_flags[STAT_BUTTON_BIT] &&
    slot_event_control[CTL_BUTTON_EN_BIT] && power_event_enable &&
    !in_d0 |=> pme_req)
    else $error("enabled button did not raise wake request");
  button_gated_a: assert property ( // RQ2
    clk_en && !slot_event_control[CTL_BUTTON_EN_BIT] &&
    (stat_flags & slot_event_control & 16'h001E) == 16'h0000 |=>
    !hotplug_irq_req && !pme_req)
    else $error("disabled button raised a request");
  irq_enables_a: assert property ( // RQ3
    clk_en && !(hotplug_interrupt_enable && message_interrupt_enable) |=>
    !hotplug_irq_req)
    else $error("interrupt without both enables");
  pme_enable_a: assert property ( // RQ4
    clk_en && !power_event_enable |=> !pme_req)
    else $error("wake request without power event enable");
  status_reset_a: assert property (disable iff (1'b0) // RQ5
    sys_rst |=> (slot_event_status & ~STATE_MASK) == STATUS_RESET)
    else $error("status reset value wrong");
  flag_sticky_a: assert property ( // RQ6
    clk_en && stat_flags[STAT_BUTTON_BIT] &&
    !(stat_wr && cfg_be[0] && cfg_wdata[STAT_BUTTON_BIT]) |=>
    stat_flags[STAT_BUTTON_BIT])
    else $error("status flag fell without a write of one");
  one_clears_a: assert property ( // RQ7
    clk_en && stat_wr && cfg_be[0] && cfg_wdata[STAT_BUTTON_BIT] &&
    !attention_button_press |=> !stat_flags[STAT_BUTTON_BIT])
    else $error("write of one did not clear flag");
  fault_follows_pin_a: assert property ( // RQ8
    clk_en && slot_power_fault_pin ##1 clk_en && slot_power_fault_pin |=>
    stat_flags[STAT_FAULT_BIT] && $past(stat_flags[STAT_FAULT_BIT]))
    else $error("fault flag not following pin");
  request_drops_a: assert property ( // RQ9
    clk_en && stat_flags == 16'h0000 |=> !hotplug_irq_req && !pme_req)
    else $error("request held with no pending flag");

  irq_rise_c: cover property (clk_en && !hotplug_irq_req ##1 hotplug_irq_req);
  pme_rise_c: cover property (clk_en && !pme_req ##1 pme_req);
  button_clear_c: cover property (
    stat_flags[STAT_BUTTON_BIT] ##1 !stat_flags[STAT_BUTTON_BIT]);
  cmd_done_c: cover property (
    ctl_wr && clk_en ##2 stat_flags[STAT_CMD_DONE_BIT]);
endmodule

/* verif/slot_event_enable_status_tb.sv */
// bench: slot event enables, status and request gating
`timescale 1ns/1ps
module slot_event_enable_status_tb;
  import sees_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
  logic cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [15:0] cfg_wdata = 16'h0000, cfg_rdata, live, d;
  logic [1:0] cfg_be = 2'h0, power_state = 2'h0;
  logic cfg_rvalid, hotplug_irq_req, pme_req;
  logic [8:0] sens = 9'h000;
  logic mie = 1'b0, pee = 1'b0;
  logic [31:0] rng = 32'd11;
  logic [15:0] expq[$];
  int fail_count = 0, compares = 0;
  sees_slot_events dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .attention_button_press(sens[0]), .slot_power_fault_pin(sens[1]),
    .latch_sensor_change(sens[2]), .presence_change(sens[3]),
    .link_state_change(sens[8]), .latch_sensor_open(sens[5]),
    .card_present(sens[6]), .interlock_engaged(sens[7]),
    .message_interrupt_enable(mie), .power_event_enable(pee),
    .power_state(power_state), .hotplug_irq_req(hotplug_irq_req),
    .pme_req(pme_req));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // read results come back in order, one per rvalid pulse
  always @(negedge core_clk) begin
    if (cfg_rvalid === 1'b1) begin
      if (expq.size() == 0) check(cfg_rdata, 16'hDEAD);
      else check(cfg_rdata, expq.pop_front());
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v,
                    input logic [1:0] be);
    @(negedge core_clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = v;
    cfg_be = be;
    @(negedge core_clk);
    cfg_wr = 1'b0;
    cfg_wdata = ~v;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] v);
    @(negedge core_clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    expq.push_back(v);
    @(negedge core_clk);
    cfg_rd = 1'b0;
    tick(1);
  endtask
  task automatic pulse(input int b);
    @(negedge core_clk);
    sens[b] = 1'b1;
    @(negedge core_clk);
    sens[b] = 1'b0;
  endtask
  task automatic req(input logic irq, input logic pme);
    tick(3);
    check({15'h0, hotplug_irq_req}, {15'h0, irq});
    check({15'h0, pme_req}, {15'h0, pme});
  endtask
  initial begin
    #50000;
    fail_count++;
    complete_run();
  end
  initial begin
    rng = xs(rng);
    sens[7:5] = rng[2:0];
    live = {8'h00, rng[2:0], 5'h00};
    tick(2);
    sys_rst = 1'b0;
    rd(SLOT_STATUS_OFS, STATUS_RESET | live);
    rd(SLOT_CONTROL_OFS, CONTROL_RESET);
    rd(8'h44, 16'h0000);
    rng = xs(rng);
    d = rng[15:0];
    wr(SLOT_CONTROL_OFS, d, 2'h3);
    rd(SLOT_CONTROL_OFS, d);
    wr(SLOT_CONTROL_OFS, 16'hFFFF, 2'h1);
    rd(SLOT_CONTROL_OFS, {d[15:8], 8'hFF});
    wr(SLOT_CONTROL_OFS, 16'h0000, 2'h3);
    rd(SLOT_CONTROL_OFS, 16'h0000);
    $display("test reset and control done");
    wr(SLOT_STATUS_OFS, 16'hFFFF, 2'h3);
    rd(SLOT_STATUS_OFS, live);
    for (int b = 0; b < 9; b++) begin
      if (FLAG_MASK[b] && b != 4) pulse(b);
    end
    rd(SLOT_STATUS_OFS, 16'h010F | live);
    wr(SLOT_STATUS_OFS, 16'h0000, 2'h3);
    rd(SLOT_STATUS_OFS, 16'h010F | live);
    wr(SLOT_STATUS_OFS, 16'h0101, 2'h1);
    rd(SLOT_STATUS_OFS, 16'h010E | live);
    wr(SLOT_STATUS_OFS, 16'h010E, 2'h3);
    rd(SLOT_STATUS_OFS, live);
    // a press while the clock enable is low must not be latched
    clk_en = 1'b0;
    pulse(0);
    clk_en = 1'b1;
    rd(SLOT_STATUS_OFS, live);
    req(1'b0, 1'b0);
    $display("test status clear done");
    // a fault that persists cannot be cleared away
    sens[1] = 1'b1;
    wr(SLOT_STATUS_OFS, 16'h0002, 2'h1);
    rd(SLOT_STATUS_OFS, 16'h0002 | live);
    sens[1] = 1'b0;
    wr(SLOT_STATUS_OFS, 16'h0002, 2'h1);
    rd(SLOT_STATUS_OFS, live);
    $display("test fault pin done");
    mie = 1'b1;
    wr(SLOT_CONTROL_OFS, 16'h0021, 2'h3);
    pulse(1);
    req(1'b0, 1'b0);
    pulse(0);
    req(1'b1, 1'b0);
    mie = 1'b0;
    req(1'b0, 1'b0);
    mie = 1'b1;
    req(1'b1, 1'b0);
    wr(SLOT_STATUS_OFS, 16'h0001, 2'h1);
    req(1'b0, 1'b0);
    wr(SLOT_CONTROL_OFS, 16'h0022, 2'h3);
    req(1'b1, 1'b0);
    for (int s = 1; s < 4; s++) begin
      power_state = s[1:0];
      pee = 1'b1;
      req(1'b0, 1'b1);
      pee = 1'b0;
      req(1'b0, 1'b0);
    end
    power_state = PSTATE_D0;
    wr(SLOT_STATUS_OFS, 16'h011F, 2'h3);
    req(1'b0, 1'b0);
    // command completion interrupt, then a reset in mid-run
    wr(SLOT_CONTROL_OFS, 16'h0030, 2'h3);
    req(1'b1, 1'b0);
    $display("test requests done");
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    rd(SLOT_STATUS_OFS, STATUS_RESET | live);
    rd(SLOT_CONTROL_OFS, CONTROL_RESET);
    req(1'b0, 1'b0);
    // every read issued must have come back
    check(16'(expq.size()), 16'h0000);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule
